// ### rtl/tmr_timer16.sv
// 16-bit timer registers, counter, compare, capture and flags
// Function
// - select codes 1 to 5 give io clock divided by 1,8,64,256,1024.
// - select code zero stops the counter.
// - code 6 counts pin falling edges, code 7 rising edges.
// - pin edges count even when the pin is an output.
// - counter is two bytes, made atomic by a high-byte latch.
// - one high-byte latch serves every 16-bit register.
// - counter write suppresses compare matches on the next timer tick.
// - both compare registers are always compared with the counter.
// - compare writes land both bytes together through the latch.
// - capture event loads the counter into the capture register.
// - capture reads return both bytes from one instant.
// - enables at mask bits 5..2; request needs enable, global, flag.
// - capture flag on capture, or at top when capture is top.
// - compare flag set the tick after counter equals compare.
// - forced compare strobe never sets a compare flag.
// - overflow flag at overflow, or where the wave mode says.
// - flags clear on vector execution or written one.
// - capture as top disconnects the capture pin.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16 (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic ext_count_pin,
   input wire logic capture_pin,
   input wire logic comparator_out,
   input wire logic [7:0] vector_ack,
   output logic irq,
   output logic cmp_a_event,
   output logic cmp_b_event
);
   typedef struct packed {
      logic [15:0] counter;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      logic [15:0] capture;
      logic [7:0] temp;
      logic [7:0] mask;
      logic [7:0] flags;
      tmr_pkg::tmr_cs_t cs;
      tmr_pkg::tmr_wgm_t wgm;
      logic cap_rise;
      logic cap_comp;
      logic gie;
      logic count_down;
      logic cmp_block;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [7:0] w_data;
      logic w_lane;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic irq;
      logic ev_a;
      logic ev_b;
   } tmr_state_t;

   tmr_state_t s;
   tmr_state_t n;
   tmr_tick_if tif ();
   logic tick;
   logic cap_ev;
   logic cap_src;
   logic cap_top;
   logic dual;
   logic fast;
   logic at_top;
   logic we;
   logic cnt_wr;
   logic flag_wr;
   logic ctrl2_wr;
   logic rd_go;
   logic mapped;
   logic [15:0] top;
   logic [7:0] wd;
   logic [7:0] set_f;
   logic [7:0] clr_f;

   // divider and count pin feed one tick
   tmr_prescale u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .ext_count_pin(ext_count_pin),
      .tif(tif.src)
   );
   assign tif.sel = s.cs;
   assign tick = tif.tick;

   // capture edges ignored while capture is top
   assign cap_src = s.cap_comp ? comparator_out : capture_pin;
   tmr_edge u_cap (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(cap_src),
      .rise_sel(s.cap_rise),
      .enable(!cap_top),
      .pulse(cap_ev)
   );

   // wave mode decode: slope, top source
   always_comb
   begin
      dual = s.wgm inside {tmr_pkg::WGM_PC8, tmr_pkg::WGM_PC9,
         tmr_pkg::WGM_PC10, tmr_pkg::WGM_PFC_CAP, tmr_pkg::WGM_PFC_A,
         tmr_pkg::WGM_PC_CAP, tmr_pkg::WGM_PC_A};
      fast = s.wgm inside {tmr_pkg::WGM_FAST8, tmr_pkg::WGM_FAST9,
         tmr_pkg::WGM_FAST10, tmr_pkg::WGM_FAST_CAP, tmr_pkg::WGM_FAST_A};
      cap_top = s.wgm inside {tmr_pkg::WGM_PFC_CAP, tmr_pkg::WGM_PC_CAP,
         tmr_pkg::WGM_CTC_CAP, tmr_pkg::WGM_FAST_CAP};
      unique case (s.wgm)
         tmr_pkg::WGM_PC8, tmr_pkg::WGM_FAST8: top = tmr_pkg::TOP8;
         tmr_pkg::WGM_PC9, tmr_pkg::WGM_FAST9: top = tmr_pkg::TOP9;
         tmr_pkg::WGM_PC10, tmr_pkg::WGM_FAST10: top = tmr_pkg::TOP10;
         tmr_pkg::WGM_CTC_A, tmr_pkg::WGM_PFC_A, tmr_pkg::WGM_PC_A,
            tmr_pkg::WGM_FAST_A: top = s.cmp_a;
         tmr_pkg::WGM_PFC_CAP, tmr_pkg::WGM_PC_CAP, tmr_pkg::WGM_CTC_CAP,
            tmr_pkg::WGM_FAST_CAP: top = s.capture;
         tmr_pkg::WGM_NORMAL, tmr_pkg::WGM_RSVD: top = tmr_pkg::CNT_MAX;
      endcase
      // single-slope counter above a lowered top runs on to wrap; dual-slope turns down
      at_top = dual ? (s.counter >= top) : (s.counter == top);
   end

   // bus strobes for this cycle
   always_comb
   begin
      wd = s.w_data;
      we = s.aw_got && s.w_got && !s.bvalid && s.w_lane;
      cnt_wr = we && s.aw_addr == tmr_pkg::OFS_CNT_LO;
      flag_wr = we && s.aw_addr == tmr_pkg::OFS_FLAGS;
      ctrl2_wr = we && s.aw_addr == tmr_pkg::OFS_CTRL2;
      rd_go = arvalid && s.arready;
      mapped = s.aw_addr inside {tmr_pkg::OFS_CNT_LO, tmr_pkg::OFS_CNT_HI,
         tmr_pkg::OFS_CMPA_LO, tmr_pkg::OFS_CMPA_HI, tmr_pkg::OFS_CMPB_LO,
         tmr_pkg::OFS_CMPB_HI, tmr_pkg::OFS_CAP_LO, tmr_pkg::OFS_CAP_HI,
         tmr_pkg::OFS_MASK, tmr_pkg::OFS_FLAGS, tmr_pkg::OFS_CTRL,
         tmr_pkg::OFS_CTRL2};
   end

   // counter, compare, capture, flags and bus, all in one next state
   always_comb
   begin
      n = s;
      set_f = tmr_pkg::NO_BITS;
      clr_f = tmr_pkg::NO_BITS;
      n.ev_a = 1'b0;
      n.ev_b = 1'b0;
      if (tick)
      begin
         n.cmp_block = 1'b0;
         // continuous compare; flag on the next tick
         if (!s.cmp_block && s.counter == s.cmp_a)
         begin
            set_f[tmr_pkg::BIT_CMPA] = 1'b1;
            n.ev_a = 1'b1;
         end
         // a blocked tick drops both matches
         if (!s.cmp_block && s.counter == s.cmp_b)
         begin
            set_f[tmr_pkg::BIT_CMPB] = 1'b1;
            n.ev_b = 1'b1;
         end
         // capture flag at top when capture is top
         if (cap_top && at_top)
            set_f[tmr_pkg::BIT_CAP] = 1'b1;
         if (dual)
         begin
            if (s.count_down && s.counter == tmr_pkg::BOTTOM)
            begin
               n.count_down = 1'b0;
               n.counter = s.counter + tmr_pkg::STEP;
               set_f[tmr_pkg::BIT_OVF] = 1'b1;
            end
            else if (!s.count_down && at_top)
            begin
               n.count_down = 1'b1;
               n.counter = s.counter - tmr_pkg::STEP;
            end
            else if (s.count_down)
               n.counter = s.counter - tmr_pkg::STEP;
            else
               n.counter = s.counter + tmr_pkg::STEP;
         end
         else
         begin
            n.count_down = 1'b0;
            n.counter = at_top ? tmr_pkg::BOTTOM : s.counter + tmr_pkg::STEP;
            // fast modes at top, normal and clear modes at max
            if (fast ? at_top : s.counter == tmr_pkg::CNT_MAX)
               set_f[tmr_pkg::BIT_OVF] = 1'b1;
         end
      end
      // capture loads counter; and sets its flag
      if (cap_ev && !cap_top)
      begin
         n.capture = s.counter;
         set_f[tmr_pkg::BIT_CAP] = 1'b1;
      end

      // write channel handshakes, taken in either order
      if (awvalid && s.awready)
      begin
         n.aw_got = 1'b1;
         n.aw_addr = awaddr;
      end
      if (wvalid && s.wready)
      begin
         n.w_got = 1'b1;
         n.w_data = wdata[7:0];
         n.w_lane = wstrb[0];
      end
      if (bready && s.bvalid)
         n.bvalid = 1'b0;
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = mapped ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end

      // read channel; counter and capture low byte reads latch the high byte
      if (rready && s.rvalid)
         n.rvalid = 1'b0;
      if (rd_go)
      begin
         n.rvalid = 1'b1;
         n.rresp = tmr_pkg::RESP_OKAY;
         n.rdata = tmr_pkg::NO_BITS;
         case (araddr)
            // counter read pairs through the latch
            tmr_pkg::OFS_CNT_LO:
            begin
               n.rdata = s.counter[7:0];
               n.temp = s.counter[15:8];
            end
            tmr_pkg::OFS_CAP_LO:
            begin
               n.rdata = s.capture[7:0];
               n.temp = s.capture[15:8];
            end
            tmr_pkg::OFS_CNT_HI, tmr_pkg::OFS_CAP_HI: n.rdata = s.temp;
            tmr_pkg::OFS_CMPA_LO: n.rdata = s.cmp_a[7:0];
            tmr_pkg::OFS_CMPA_HI: n.rdata = s.cmp_a[15:8];
            tmr_pkg::OFS_CMPB_LO: n.rdata = s.cmp_b[7:0];
            tmr_pkg::OFS_CMPB_HI: n.rdata = s.cmp_b[15:8];
            tmr_pkg::OFS_MASK: n.rdata = s.mask;
            tmr_pkg::OFS_FLAGS: n.rdata = s.flags;
            tmr_pkg::OFS_CTRL: n.rdata = {s.cap_rise, s.wgm, s.cs};
            // force strobes always read back as zero
            tmr_pkg::OFS_CTRL2: n.rdata = {6'h00, s.cap_comp, s.gie};
            default: n.rresp = tmr_pkg::RESP_SLVERR;
         endcase
      end

      // register writes; a counter write overrides counting
      if (we)
      begin
         case (s.aw_addr)
            // every high byte goes to the one latch
            tmr_pkg::OFS_CNT_HI, tmr_pkg::OFS_CMPA_HI, tmr_pkg::OFS_CMPB_HI,
               tmr_pkg::OFS_CAP_HI: n.temp = wd;
            // low byte write commits latch plus byte
            tmr_pkg::OFS_CNT_LO:
            begin
               n.counter = {s.temp, wd};
               // suppress matches on the next tick
               n.cmp_block = 1'b1;
            end
            tmr_pkg::OFS_CMPA_LO: n.cmp_a = {s.temp, wd};
            tmr_pkg::OFS_CMPB_LO: n.cmp_b = {s.temp, wd};
            tmr_pkg::OFS_CAP_LO: n.capture = {s.temp, wd};
            tmr_pkg::OFS_MASK: n.mask = wd;
            // write one clears; zero leaves it
            tmr_pkg::OFS_FLAGS: clr_f = wd & tmr_pkg::FLAG_BITS;
            tmr_pkg::OFS_CTRL:
            begin
               n.cs = tmr_pkg::tmr_cs_t'(wd[tmr_pkg::CS_HI:tmr_pkg::CS_LO]);
               n.wgm = tmr_pkg::tmr_wgm_t'(wd[tmr_pkg::WGM_HI:tmr_pkg::WGM_LO]);
               n.cap_rise = wd[tmr_pkg::CAP_RISE];
            end
            tmr_pkg::OFS_CTRL2:
            begin
               n.gie = wd[tmr_pkg::GIE];
               n.cap_comp = wd[tmr_pkg::CAP_COMP];
               // force strobes pulse the event, never a flag
               n.ev_a = n.ev_a | wd[tmr_pkg::FORCE_A];
               n.ev_b = n.ev_b | wd[tmr_pkg::FORCE_B];
            end
            default: n.temp = s.temp;
         endcase
      end

      // vector and software clears; a same-cycle set wins
      clr_f = clr_f | (vector_ack & tmr_pkg::FLAG_BITS);
      n.flags = (s.flags & ~clr_f) | set_f;
      // request needs global enable, mask bit and flag
      n.irq = n.gie && |(n.flags & n.mask & tmr_pkg::FLAG_BITS);
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;
      n.arready = !n.rvalid;
   end

   // register the state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '0;
      else
         s <= n;
   end

   // outputs straight from the state register
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = {24'h000000, s.rdata};
   assign irq = s.irq;
   assign cmp_a_event = s.ev_a;
   assign cmp_b_event = s.ev_b;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_stop_holds: assert property (
      s.cs == tmr_pkg::CS_STOP && $past(s.cs) == tmr_pkg::CS_STOP
      && !cnt_wr |=> s.counter == $past(s.counter))
      else $error("counter moved while stopped");
   a_cmpa_flag: assert property (
      tick && !s.cmp_block && s.counter == s.cmp_a
      |=> s.flags[tmr_pkg::BIT_CMPA] && s.ev_a)
      else $error("compare a match missed");
   a_block_match: assert property (
      cnt_wr ##1 (tick && s.counter == s.cmp_a
      && !s.flags[tmr_pkg::BIT_CMPA]) |=> !s.flags[tmr_pkg::BIT_CMPA])
      else $error("match not suppressed after counter write");
   a_irq_gate: assert property (
      s.irq |-> s.gie && |(s.flags & s.mask & tmr_pkg::FLAG_BITS))
      else $error("irq without enabled flag");
   a_capture_load: assert property (
      cap_ev && !cap_top && !we
      |=> s.capture == $past(s.counter) && s.flags[tmr_pkg::BIT_CAP])
      else $error("capture did not load counter");
   a_cap_top_off: assert property (
      cap_top && !we |=> s.capture == $past(s.capture))
      else $error("capture changed while capture is top");
   a_cnt_atomic: assert property (
      cnt_wr |=> s.counter == {$past(s.temp), $past(s.w_data)})
      else $error("counter write not atomic");
   a_zero_keeps: assert property (
      flag_wr && !s.w_data[tmr_pkg::BIT_OVF] && s.flags[tmr_pkg::BIT_OVF]
      && !vector_ack[tmr_pkg::BIT_OVF] |=> s.flags[tmr_pkg::BIT_OVF])
      else $error("zero write cleared a flag");
   a_one_clears: assert property (
      flag_wr && s.w_data[tmr_pkg::BIT_OVF] && !tick
      |=> !s.flags[tmr_pkg::BIT_OVF])
      else $error("one write left flag set");
   a_force_noflag: assert property (
      ctrl2_wr && s.w_data[tmr_pkg::FORCE_A] && !tick
      && !s.flags[tmr_pkg::BIT_CMPA]
      |=> s.ev_a && !s.flags[tmr_pkg::BIT_CMPA])
      else $error("force strobe set compare flag");
   a_cap_read: assert property (
      rd_go && araddr == tmr_pkg::OFS_CAP_LO && !we
      |=> s.temp == $past(s.capture[15:8]) && s.rvalid)
      else $error("capture high byte not latched");
   a_ovf_normal: assert property (
      tick && s.wgm == tmr_pkg::WGM_NORMAL && s.counter == tmr_pkg::CNT_MAX
      && !cnt_wr |=> s.flags[tmr_pkg::BIT_OVF]
      && s.counter == tmr_pkg::BOTTOM)
      else $error("normal mode overflow missed");
endmodule
`default_nettype wire

// ### rtl/tmr_pkg.sv
// constants and types shared by the 16-bit timer block
`default_nettype none
package tmr_pkg;
   // register byte addresses, one aligned word each
   localparam logic [7:0] OFS_CNT_LO = 8'h00;
   localparam logic [7:0] OFS_CNT_HI = 8'h04;
   localparam logic [7:0] OFS_CMPA_LO = 8'h08;
   localparam logic [7:0] OFS_CMPA_HI = 8'h0c;
   localparam logic [7:0] OFS_CMPB_LO = 8'h10;
   localparam logic [7:0] OFS_CMPB_HI = 8'h14;
   localparam logic [7:0] OFS_CAP_LO = 8'h18;
   localparam logic [7:0] OFS_CAP_HI = 8'h1c;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_FLAGS = 8'h24;
   localparam logic [7:0] OFS_CTRL = 8'h28;
   localparam logic [7:0] OFS_CTRL2 = 8'h2c;
   // flag and mask bit positions
   localparam int BIT_CAP = 5;
   localparam int BIT_CMPA = 4;
   localparam int BIT_CMPB = 3;
   localparam int BIT_OVF = 2;
   localparam logic [7:0] FLAG_BITS = 8'h3c;
   localparam logic [7:0] NO_BITS = 8'h00;
   // control field positions
   localparam int CS_LO = 0;
   localparam int CS_HI = 2;
   localparam int WGM_LO = 3;
   localparam int WGM_HI = 6;
   localparam int CAP_RISE = 7;
   localparam int GIE = 0;
   localparam int CAP_COMP = 1;
   localparam int FORCE_A = 2;
   localparam int FORCE_B = 3;
   // counter landmarks
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] STEP = 16'h0001;
   localparam logic [15:0] TOP8 = 16'h00ff;
   localparam logic [15:0] TOP9 = 16'h01ff;
   localparam logic [15:0] TOP10 = 16'h03ff;
   // prescaler tap masks
   localparam logic [9:0] PRE_STEP = 10'h001;
   localparam logic [9:0] PRE_M8 = 10'h007;
   localparam logic [9:0] PRE_M64 = 10'h03f;
   localparam logic [9:0] PRE_M256 = 10'h0ff;
   localparam logic [9:0] PRE_M1024 = 10'h3ff;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [2:0] {
      CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010,
      CS_DIV64 = 3'b011, CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101,
      CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
   } tmr_cs_t;
   typedef enum logic [3:0] {
      WGM_NORMAL = 4'b0000, WGM_PC8 = 4'b0001, WGM_PC9 = 4'b0010,
      WGM_PC10 = 4'b0011, WGM_CTC_A = 4'b0100, WGM_FAST8 = 4'b0101,
      WGM_FAST9 = 4'b0110, WGM_FAST10 = 4'b0111, WGM_PFC_CAP = 4'b1000,
      WGM_PFC_A = 4'b1001, WGM_PC_CAP = 4'b1010, WGM_PC_A = 4'b1011,
      WGM_CTC_CAP = 4'b1100, WGM_RSVD = 4'b1101, WGM_FAST_CAP = 4'b1110,
      WGM_FAST_A = 4'b1111
   } tmr_wgm_t;
endpackage
`default_nettype wire

// ### rtl/tmr_tick_if.sv
// clock select and timer tick between divider and counter
`timescale 1ns/1ps
`default_nettype none
interface tmr_tick_if;
   tmr_pkg::tmr_cs_t sel;
   logic tick;
   modport src (input sel, output tick);
   modport dst (output sel, input tick);
endinterface
`default_nettype wire

// ### rtl/tmr_edge.sv
// one-cycle pulse on a chosen edge of a synchronous level
`timescale 1ns/1ps
`default_nettype none
module tmr_edge (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic level,
   input wire logic rise_sel,
   input wire logic enable,
   output logic pulse
);
   typedef struct packed {
      logic prev;
      logic pulse;
   } tmr_edge_st_t;
   tmr_edge_st_t s;
   tmr_edge_st_t n;

   // compare level against last sample
   always_comb
   begin
      n.prev = level;
      n.pulse = enable && (rise_sel ? (!s.prev && level) : (s.prev && !level));
   end

   // register the state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '0;
      else
         s <= n;
   end

   assign pulse = s.pulse;
endmodule
`default_nettype wire

// ### rtl/tmr_prescale.sv
// prescaler and count pin edge detect giving the timer tick
`timescale 1ns/1ps
`default_nettype none
module tmr_prescale (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ext_count_pin,
   tmr_tick_if.src tif
);
   typedef struct packed {
      logic [9:0] pre;
      logic pin_q;
      logic tick;
   } tmr_pre_st_t;
   tmr_pre_st_t s;
   tmr_pre_st_t n;

   // free-running divider, shared by all taps so no resync
   always_comb
   begin
      n = s;
      n.pre = s.pre + tmr_pkg::PRE_STEP;
      // pin level taken whatever its direction
      n.pin_q = ext_count_pin;
      unique case (tif.sel)
         tmr_pkg::CS_STOP: n.tick = 1'b0;
         tmr_pkg::CS_DIV1: n.tick = 1'b1;
         tmr_pkg::CS_DIV8: n.tick = &(s.pre | ~tmr_pkg::PRE_M8);
         tmr_pkg::CS_DIV64: n.tick = &(s.pre | ~tmr_pkg::PRE_M64);
         tmr_pkg::CS_DIV256: n.tick = &(s.pre | ~tmr_pkg::PRE_M256);
         tmr_pkg::CS_DIV1024: n.tick = &(s.pre | ~tmr_pkg::PRE_M1024);
         tmr_pkg::CS_EXT_FALL: n.tick = s.pin_q && !ext_count_pin;
         tmr_pkg::CS_EXT_RISE: n.tick = !s.pin_q && ext_count_pin;
      endcase
   end

   // register the state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '0;
      else
         s <= n;
   end

   assign tif.tick = s.tick;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_ext_fall: assert property (
      tif.sel == tmr_pkg::CS_EXT_FALL && s.pin_q && !ext_count_pin
      |=> s.tick)
      else $error("falling pin edge gave no tick");
   a_stop_quiet: assert property (
      tif.sel == tmr_pkg::CS_STOP |=> !s.tick)
      else $error("tick while stopped");
endmodule
`default_nettype wire

// ### testbench/tmr_timer16_bench.sv
// self-checking bench for the 16-bit timer registers and flags
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16_bench;
   logic aclk = 1'b0;
   logic aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic ext_pin, cap_pin, cmp_out, ev_a, ev_b;
   logic [7:0] awaddr, araddr, vector_ack;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [15:0] v16, r;
   // register model: committed 16-bit values and the shared latch
   logic [15:0] mdl[logic [7:0]];
   logic [7:0] mdl_hi = 8'h00;
   int err_total = 0;
   int n_checks = 0;
   int divs[$] = '{1, 8, 64, 256, 1024};

   // 4 ns period
   always #2 aclk = ~aclk;

   tmr_timer16 i_tmr_timer16 (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .ext_count_pin(ext_pin), .capture_pin(cap_pin),
      .comparator_out(cmp_out), .vector_ack(vector_ack), .irq(irq),
      .cmp_a_event(ev_a), .cmp_b_event(ev_b));

   // verdict, the single place where the run ends
   task automatic conclude();
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         aw_ok = aw_ok | (awvalid & awready);
         w_ok = w_ok | (wvalid & wready);
         awvalid <= awvalid & ~awready;
         wvalid <= wvalid & ~wready;
      end
      do @(posedge aclk); while (!bvalid);
      resp = bresp;
      // model: high bytes park in one latch, a low byte commits both
      if (wstrb[0] && a < tmr_pkg::OFS_MASK)
      begin
         if (a[2])
            mdl_hi = d;
         else
            mdl[a] = {mdl_hi, d};
      end
   endtask

   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rv = rdata;
      resp = rresp;
   endtask

   // low byte first, so the high byte comes from the same instant
   task automatic rd16(input logic [7:0] a);
      rd(a);
      v16[7:0] = rv[7:0];
      rd(a + 8'h04);
      v16[15:8] = rv[7:0];
   endtask

   // high byte parks in the latch until the low byte commits
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a + 8'h04, d[15:8]);
      wr(a, d[7:0]);
   endtask

   // watchdog, well past the longest prescaler run
   initial
   begin
      repeat (60000) @(posedge aclk);
      err_total++;
      conclude();
   end

   initial
   begin
      // responses always accepted: bready and rready stand high
      {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h0a;
      {awaddr, araddr, vector_ack, wdata} = 56'h0;
      {ext_pin, cap_pin, cmp_out, wstrb} = 7'h0f;
      void'($urandom(73363));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // a write with the low lane off must change nothing
      wstrb <= 4'he;
      wr(tmr_pkg::OFS_MASK, 8'hff);
      wstrb <= 4'hf;
      // reset values and an unmapped place
      rd(tmr_pkg::OFS_MASK);
      chk(rv[15:0], 16'h0000);
      rd(tmr_pkg::OFS_FLAGS);
      chk(rv[15:0], 16'h0000);
      rd(8'h3c);
      chk({14'h0, resp}, {14'h0, tmr_pkg::RESP_SLVERR});
      wr(8'h3c, 8'hff);
      chk({14'h0, resp}, {14'h0, tmr_pkg::RESP_SLVERR});
      // stopped counter keeps a random value
      r = 16'($urandom);
      wr16(tmr_pkg::OFS_CNT_LO, r);
      repeat (20) @(posedge aclk);
      rd16(tmr_pkg::OFS_CNT_LO);
      chk(v16, mdl[tmr_pkg::OFS_CNT_LO]);
      // high byte written for A lands in B: one latch
      wr(tmr_pkg::OFS_CMPA_HI, 8'hab);
      wr(tmr_pkg::OFS_CMPB_LO, 8'h11);
      rd16(tmr_pkg::OFS_CMPB_LO);
      chk(v16, mdl[tmr_pkg::OFS_CMPB_LO]);
      // ten prescaled periods give about ten ticks, bus slack allowed
      foreach (divs[i])
      begin
         wr16(tmr_pkg::OFS_CNT_LO, 16'h0000);
         wr(tmr_pkg::OFS_CTRL, 8'(i + 1));
         repeat (divs[i] * 10) @(posedge aclk);
         wr(tmr_pkg::OFS_CTRL, 8'h00);
         rd16(tmr_pkg::OFS_CNT_LO);
         chk(16'(v16 >= 9 && v16 <= 16), 16'h0001);
      end
      // rising then falling pin edges, toggle counts tell them apart
      wr16(tmr_pkg::OFS_CNT_LO, 16'h0000);
      for (int m = 0; m < 2; m++)
      begin
         wr(tmr_pkg::OFS_CTRL, 8'h07 - 8'(m));
         repeat (3 + 2 * m)
         begin
            ext_pin <= ~ext_pin;
            repeat (4) @(posedge aclk);
         end
         wr(tmr_pkg::OFS_CTRL, 8'h00);
         rd16(tmr_pkg::OFS_CNT_LO);
         chk(v16, (m == 1) ? 16'h0005 : 16'h0002);
      end
      // compare matches, mask and global enable
      wr16(tmr_pkg::OFS_CMPA_LO, 16'h0020);
      wr16(tmr_pkg::OFS_CMPB_LO, 16'h0030);
      wr16(tmr_pkg::OFS_CNT_LO, 16'h0000);
      wr(tmr_pkg::OFS_FLAGS, 8'h3c);
      wr(tmr_pkg::OFS_MASK, 8'h3c);
      wr(tmr_pkg::OFS_CTRL2, 8'h01);
      wr(tmr_pkg::OFS_CTRL, 8'h01);
      repeat (80) @(posedge aclk);
      wr(tmr_pkg::OFS_CTRL, 8'h00);
      rd(tmr_pkg::OFS_FLAGS);
      chk(rv[15:0], 16'h0018);
      chk({15'h0, irq}, 16'h0001);
      wr(tmr_pkg::OFS_MASK, 8'h00);
      repeat (2) @(posedge aclk);
      chk({15'h0, irq}, 16'h0000);
      wr(tmr_pkg::OFS_MASK, 8'h3c);
      wr(tmr_pkg::OFS_CTRL2, 8'h00);
      repeat (2) @(posedge aclk);
      chk({15'h0, irq}, 16'h0000);
      wr(tmr_pkg::OFS_CTRL2, 8'h01);
      wr(tmr_pkg::OFS_FLAGS, 8'h00);
      rd(tmr_pkg::OFS_FLAGS);
      chk(rv[15:0], 16'h0018);
      wr(tmr_pkg::OFS_FLAGS, 8'h10);
      rd(tmr_pkg::OFS_FLAGS);
      chk(rv[15:0], 16'h0008);
      vector_ack <= 8'h08;
      @(posedge aclk);
      vector_ack <= 8'h00;
      rd(tmr_pkg::OFS_FLAGS);
      chk(rv[15:0], 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      // wrap past all ones, stopped well short of the compares
      wr16(tmr_pkg::OFS_CNT_LO, 16'hfff0);
      wr(tmr_pkg::OFS_CTRL, 8'h01);
      repeat (25) @(posedge aclk);
      wr(tmr_pkg::OFS_CTRL, 8'h00);
      rd(tmr_pkg::OFS_FLAGS);
      chk(rv[15:0], 16'h0004);
      wr(tmr_pkg::OFS_FLAGS, 8'h3c);
      // running counter written onto the A match, then forced strobes
      wr(tmr_pkg::OFS_CNT_HI, 8'h00);
      wr(tmr_pkg::OFS_CTRL, 8'h01);
      wr(tmr_pkg::OFS_CNT_LO, 8'h20);
      wr(tmr_pkg::OFS_CTRL, 8'h00);
      wr(tmr_pkg::OFS_CTRL2, 8'h0d);
      chk({14'h0, ev_a, ev_b}, 16'h0003);
      rd(tmr_pkg::OFS_FLAGS);
      chk(rv[15:0], 16'h0000);
      // capture from the pin, then from the comparator
      wr16(tmr_pkg::OFS_CNT_LO, r);
      wr(tmr_pkg::OFS_CTRL, 8'h80);
      cap_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      rd16(tmr_pkg::OFS_CAP_LO);
      chk(v16, mdl[tmr_pkg::OFS_CNT_LO]);
      rd(tmr_pkg::OFS_FLAGS);
      chk(rv[15:0], 16'h0020);
      wr(tmr_pkg::OFS_CTRL2, 8'h03);
      wr16(tmr_pkg::OFS_CNT_LO, ~r);
      cmp_out <= 1'b1;
      repeat (4) @(posedge aclk);
      rd16(tmr_pkg::OFS_CAP_LO);
      chk(v16, mdl[tmr_pkg::OFS_CNT_LO]);
      // capture as top: a pin edge must change nothing
      wr(tmr_pkg::OFS_FLAGS, 8'h3c);
      wr(tmr_pkg::OFS_CTRL2, 8'h01);
      wr(tmr_pkg::OFS_CTRL, 8'he0);
      wr16(tmr_pkg::OFS_CNT_LO, 16'h0777);
      cap_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      cap_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      rd16(tmr_pkg::OFS_CAP_LO);
      chk(v16, ~r);
      conclude();
   end
endmodule
`default_nettype wire
